//--- hdl/shms_apb_regs.sv
// apb register file of the heater sequencer
`timescale 1ns/10ps
`include "shms_params.svh"
module shms_apb_regs (
	// clock and reset
	input  wire logic              clk_sys_in,
	input  wire logic              sys_rst_in,
	// apb slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	// sequencer side
	input  wire logic [7:0]        status_in,
	output shms_pkg::shms_cfg_s    cfg_out,
	output logic                   bake_go_out
);
	import shms_pkg::*;

	shms_cfg_s   cfg_ff;
	shms_cfg_s   nxt_cfg;
	logic        go_ff;
	logic        nxt_go;
	logic [31:0] rd_ff;
	logic [31:0] nxt_rd;
	logic        err;
	logic        acc;

	assign acc = psel & penable;

	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_go  = 1'b0;
		nxt_rd  = 32'h0;
		err     = 1'b0;
		unique case (paddr)
			`SHMS_OFS_CTRL:        nxt_rd = {30'h0, cfg_ff.period_en, cfg_ff.purge_en};
			`SHMS_OFS_SETPOINT:    nxt_rd = {22'h0, cfg_ff.setpoint};
			`SHMS_OFS_BAKE_HEAT:   nxt_rd = {12'h0, cfg_ff.bake_heat_s};
			`SHMS_OFS_BAKE_COOL:   nxt_rd = {12'h0, cfg_ff.bake_cool_s};
			`SHMS_OFS_BAKE_PERIOD: nxt_rd = {12'h0, cfg_ff.bake_period_s};
			`SHMS_OFS_STATUS:      nxt_rd = {24'h0, status_in};
			default:               err    = 1'b1;
		endcase
		if (acc && pwrite) begin
			unique case (paddr)
				`SHMS_OFS_CTRL: begin
					nxt_cfg.purge_en  = pwdata[`SHMS_CTRL_PURGE_EN];
					nxt_cfg.period_en = pwdata[`SHMS_CTRL_PERIOD_EN];
					nxt_go            = pwdata[`SHMS_CTRL_BAKE_GO];
				end
				`SHMS_OFS_SETPOINT:    nxt_cfg.setpoint      = pwdata[9:0];
				`SHMS_OFS_BAKE_HEAT:   nxt_cfg.bake_heat_s   = pwdata[19:0];
				`SHMS_OFS_BAKE_COOL:   nxt_cfg.bake_cool_s   = pwdata[19:0];
				`SHMS_OFS_BAKE_PERIOD: nxt_cfg.bake_period_s = pwdata[19:0];
				default:               nxt_cfg = cfg_ff;
			endcase
		end
		if (!(psel && !penable) || pwrite) begin
			nxt_rd = 32'h0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cfg_ff.purge_en      <= 1'b0;
			cfg_ff.period_en     <= 1'b0;
			cfg_ff.setpoint      <= `SHMS_RST_SETPOINT;
			cfg_ff.bake_heat_s   <= 20'(`SHMS_BAKE_HEAT_S);
			cfg_ff.bake_cool_s   <= 20'(`SHMS_BAKE_COOL_S);
			cfg_ff.bake_period_s <= 20'(`SHMS_BAKE_PERIOD_S);
			go_ff                <= 1'b0;
			rd_ff                <= 32'h0;
		end else begin
			cfg_ff <= nxt_cfg;
			go_ff  <= nxt_go;
			rd_ff  <= nxt_rd;
		end
	end

	assign prdata      = rd_ff;
	assign pready      = 1'b1;
	assign pslverr     = acc & err;
	assign cfg_out     = cfg_ff;
	assign bake_go_out = go_ff;

endmodule

//--- hdl/shms_params.svh
// timing counts, register offsets, field positions and reset values for the heater sequencer
`ifndef SHMS_PARAMS_SVH
`define SHMS_PARAMS_SVH

// ----------------------------------------
// timebase
// ----------------------------------------
`define SHMS_CLK_HZ          100000000
`define SHMS_TICK_HZ         1
`define SHMS_TICK_DIV        (`SHMS_CLK_HZ / `SHMS_TICK_HZ)

// ----------------------------------------
// times in seconds and minutes
// ----------------------------------------
`define SHMS_PURGE_HEAT_S    10
`define SHMS_PURGE_COOL_MIN  3
`define SHMS_PURGE_LOCK_MIN  30
`define SHMS_BAKE_HEAT_MIN   20
`define SHMS_BAKE_COOL_MIN   4
`define SHMS_BAKE_PERIOD_MIN 1440
`define SHMS_PURGE_COOL_S    (`SHMS_PURGE_COOL_MIN * 60)
`define SHMS_PURGE_LOCK_S    (`SHMS_PURGE_LOCK_MIN * 60)
`define SHMS_BAKE_HEAT_S     (`SHMS_BAKE_HEAT_MIN * 60)
`define SHMS_BAKE_COOL_S     (`SHMS_BAKE_COOL_MIN * 60)
`define SHMS_BAKE_PERIOD_S   (`SHMS_BAKE_PERIOD_MIN * 60)

// ----------------------------------------
// register offsets
// ----------------------------------------
`define SHMS_OFS_CTRL        12'h000
`define SHMS_OFS_SETPOINT    12'h004
`define SHMS_OFS_BAKE_HEAT   12'h008
`define SHMS_OFS_BAKE_COOL   12'h00C
`define SHMS_OFS_BAKE_PERIOD 12'h010
`define SHMS_OFS_STATUS      12'h014

// ----------------------------------------
// control fields
// ----------------------------------------
`define SHMS_CTRL_PURGE_EN   0
`define SHMS_CTRL_PERIOD_EN  1
`define SHMS_CTRL_BAKE_GO    2

// ----------------------------------------
// reset values
// ----------------------------------------
`define SHMS_RST_SETPOINT    10'd990

`endif

//--- hdl/shms_pkg.sv
// types shared by the heater sequencer files
package shms_pkg;

	typedef enum logic [2:0] {
		SHMS_IDLE,
		SHMS_PURGE_HEAT,
		SHMS_PURGE_COOL,
		SHMS_BAKE_HEAT,
		SHMS_BAKE_COOL
	} shms_state_e;

	typedef struct packed {
		logic [15:0] out_a;
		logic [15:0] out_b;
	} shms_analog_s;

	typedef struct packed {
		logic        purge_en;
		logic        period_en;
		logic [9:0]  setpoint;
		logic [19:0] bake_heat_s;
		logic [19:0] bake_cool_s;
		logic [19:0] bake_period_s;
	} shms_cfg_s;

endpackage

//--- hdl/shms_sequencer.sv
// heater mode sequencer: purge, bake-out, continuous overheat, output freeze
// ----------------------------------------
// Notes on behaviour
// - humidity at setpoint starts a purge
// - purge heats at full power 10 s
// - purge cool-down 3 min, heater off
// - 30 min lockout, then restart if humid
// - both outputs held during purge cycle
// - bake-out starts: button, period, external
// - bake-out heating time is configurable
// - both outputs held during bake-out cycle
// - dual-heat variant: overheat always on
// - overheat variant disables purge only
// - reset: purge off, setpoint 99 %
// ----------------------------------------
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/10ps
`include "shms_params.svh"
module shms_sequencer #(
	parameter int TICK_DIV = `SHMS_TICK_DIV,
	parameter bit DUAL_HEAT = 1'b0
) (
	// clock and reset
	input  wire logic                  clk_sys_in,
	input  wire logic                  sys_rst_in,
	// apb slave
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [11:0]           paddr,
	input  wire logic [31:0]           pwdata,
	output logic      [31:0]           prdata,
	output logic                       pready,
	output logic                       pslverr,
	// measurement and triggers
	input  wire logic [9:0]            humidity_in,
	input  wire logic                  board_pushbutton_in,
	input  wire logic                  ext_trigger_in,
	input  wire shms_pkg::shms_analog_s analog_in,
	// heater and outputs
	output logic                       heater_full_out,
	output logic                       continuous_overheat_out,
	output shms_pkg::shms_analog_s     analog_out,
	output logic                       frozen_out
);
	import shms_pkg::*;

	initial begin
		if (TICK_DIV < 2) $error("tick divider below 2");
	end

	// ----------------------------------------
	// timebase and registers
	// ----------------------------------------
	logic        tick;
	shms_cfg_s   cfg;
	logic        bake_go;
	logic [7:0]  status;

	shms_tick_div #(
		.DIV (TICK_DIV)
	) u_tick (
		.clk_sys_in (clk_sys_in),
		.sys_rst_in (sys_rst_in),
		.tick_out   (tick)
	);

	shms_apb_regs u_regs (
		.clk_sys_in  (clk_sys_in),
		.sys_rst_in  (sys_rst_in),
		.psel        (psel),
		.penable     (penable),
		.pwrite      (pwrite),
		.paddr       (paddr),
		.pwdata      (pwdata),
		.prdata      (prdata),
		.pready      (pready),
		.pslverr     (pslverr),
		.status_in   (status),
		.cfg_out     (cfg),
		.bake_go_out (bake_go)
	);

	// ----------------------------------------
	// trigger edges
	// ----------------------------------------
	logic btn_ff;
	logic nxt_btn;
	logic ext_ff;
	logic nxt_ext;
	logic btn_rise;
	logic ext_rise;

	always_comb begin
		nxt_btn  = board_pushbutton_in;
		nxt_ext  = ext_trigger_in;
		btn_rise = board_pushbutton_in & ~btn_ff;
		ext_rise = ext_trigger_in & ~ext_ff;
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			btn_ff <= 1'b0;
			ext_ff <= 1'b0;
		end else begin
			btn_ff <= nxt_btn;
			ext_ff <= nxt_ext;
		end
	end

	// ----------------------------------------
	// periodic bake-out timer
	// ----------------------------------------
	logic [19:0] per_ff;
	logic [19:0] nxt_per;
	logic        per_hit;

	always_comb begin
		nxt_per = per_ff;
		per_hit = 1'b0;
		if (!cfg.period_en) begin
			nxt_per = 20'h0;
		end else if (tick) begin
			if (per_ff + 20'h1 >= cfg.bake_period_s) begin
				nxt_per = 20'h0;
				per_hit = 1'b1;
			end else begin
				nxt_per = per_ff + 20'h1;
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			per_ff <= 20'h0;
		end else begin
			per_ff <= nxt_per;
		end
	end

	// ----------------------------------------
	// bake-out and purge requests
	// ----------------------------------------
	logic bake_req;
	logic purge_ok;
	logic purge_req;

	assign bake_req  = btn_rise | ext_rise | per_hit | bake_go;
	assign purge_ok  = cfg.purge_en & ~DUAL_HEAT;
	assign purge_req = purge_ok & (humidity_in >= cfg.setpoint);

	// ----------------------------------------
	// mode state machine
	// ----------------------------------------
	shms_state_e state_ff;
	shms_state_e nxt_state;
	logic [19:0] sec_ff;
	logic [19:0] nxt_sec;
	logic [19:0] lock_ff;
	logic [19:0] nxt_lock;
	logic        sec_done;

	assign sec_done = tick && (sec_ff <= 20'h1);

	always_comb begin
		nxt_state = state_ff;
		nxt_sec   = sec_ff;
		nxt_lock  = lock_ff;
		if (tick && sec_ff != 20'h0) begin
			nxt_sec = sec_ff - 20'h1;
		end
		if (tick && lock_ff != 20'h0) begin
			nxt_lock = lock_ff - 20'h1;
		end
		unique case (state_ff)
			SHMS_IDLE: begin
				if (bake_req) begin
					nxt_state = SHMS_BAKE_HEAT;
					nxt_sec   = cfg.bake_heat_s;
				end else if (purge_req && lock_ff == 20'h0) begin
					nxt_state = SHMS_PURGE_HEAT;
					nxt_sec   = 20'(`SHMS_PURGE_HEAT_S);
				end
			end
			SHMS_PURGE_HEAT: begin
				if (sec_done) begin
					nxt_state = SHMS_PURGE_COOL;
					nxt_sec   = 20'(`SHMS_PURGE_COOL_S);
					nxt_lock  = 20'(`SHMS_PURGE_LOCK_S);
				end
			end
			SHMS_PURGE_COOL: begin
				if (sec_done) begin
					nxt_state = SHMS_IDLE;
				end
			end
			SHMS_BAKE_HEAT: begin
				if (sec_done) begin
					nxt_state = SHMS_BAKE_COOL;
					nxt_sec   = cfg.bake_cool_s;
				end
			end
			SHMS_BAKE_COOL: begin
				if (sec_done) begin
					nxt_state = SHMS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state_ff <= SHMS_IDLE;
			sec_ff   <= 20'h0;
			lock_ff  <= 20'h0;
		end else begin
			state_ff <= nxt_state;
			sec_ff   <= nxt_sec;
			lock_ff  <= nxt_lock;
		end
	end

	// ----------------------------------------
	// heater and analogue freeze
	// ----------------------------------------
	logic         heat_ff;
	logic         nxt_heat;
	logic         frz_ff;
	logic         nxt_frz;
	shms_analog_s ana_ff;
	shms_analog_s nxt_ana;

	always_comb begin
		nxt_heat = (nxt_state == SHMS_PURGE_HEAT) || (nxt_state == SHMS_BAKE_HEAT);
		nxt_frz  = (nxt_state != SHMS_IDLE);
		nxt_ana  = ana_ff;
		if (!nxt_frz || state_ff == SHMS_IDLE) begin
			nxt_ana = nxt_frz ? ana_ff : analog_in;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			heat_ff <= 1'b0;
			frz_ff  <= 1'b0;
			ana_ff  <= '0;
		end else begin
			heat_ff <= nxt_heat;
			frz_ff  <= nxt_frz;
			ana_ff  <= nxt_ana;
		end
	end

	assign heater_full_out         = heat_ff;
	assign continuous_overheat_out = DUAL_HEAT;
	assign analog_out              = ana_ff;
	assign frozen_out              = frz_ff;
	assign status = {2'b0, lock_ff != 20'h0, purge_ok, frz_ff, heat_ff, state_ff == SHMS_BAKE_HEAT ||
		state_ff == SHMS_BAKE_COOL, state_ff == SHMS_PURGE_HEAT || state_ff == SHMS_PURGE_COOL};

endmodule

//--- hdl/shms_tick_div.sv
// divider that makes the one-second enable pulse
`timescale 1ns/10ps
module shms_tick_div #(
	parameter int DIV = 100000000
) (
	// clock and reset
	input  wire logic clk_sys_in,
	input  wire logic sys_rst_in,
	// enable pulse
	output logic      tick_out
);

	initial begin
		if (DIV < 2) $error("divider below 2");
	end

	logic [31:0] cnt_ff;
	logic [31:0] nxt_cnt;
	logic        tick_ff;
	logic        nxt_tick;

	always_comb begin
		nxt_tick = 1'b0;
		nxt_cnt  = cnt_ff + 32'h1;
		if (cnt_ff == 32'(DIV - 1)) begin
			nxt_cnt  = 32'h0;
			nxt_tick = 1'b1;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cnt_ff  <= 32'h0;
			tick_ff <= 1'b0;
		end else begin
			cnt_ff  <= nxt_cnt;
			tick_ff <= nxt_tick;
		end
	end

	assign tick_out = tick_ff;

endmodule

//--- tb/shms_env_model.sv
// model of the humidity path and live analogue values
`timescale 1ns/10ps
module shms_env_model (
	// clock and target
	input  wire logic             clk_sys_in,
	input  wire logic [9:0]       rh_target_in,
	// measured values
	output logic      [9:0]       humidity_out,
	output shms_pkg::shms_analog_s analog_out
);
	import shms_pkg::*;
	initial begin
		humidity_out = 10'h1F4;
		analog_out = '0;
	end
	// live values change every cycle so a held output is visible
	always @(posedge clk_sys_in) begin
		humidity_out <= rh_target_in;
		analog_out <= {analog_out.out_a + 16'h0001, ~analog_out.out_b};
	end
endmodule

//--- tb/shms_seq_monitor.sv
// port checker of the heater sequencer
`timescale 1ns/10ps
module shms_seq_monitor import shms_pkg::*; #(
	parameter bit DUAL_HEAT = 1'b0
) (
	input wire logic         clk_sys_in,
	input wire logic         sys_rst_in,
	input wire logic         board_pushbutton_in,
	input wire logic         ext_trigger_in,
	input wire shms_analog_s analog_in,
	input wire logic         heater_full_out,
	input wire logic         continuous_overheat_out,
	input wire shms_analog_s analog_out,
	input wire logic         frozen_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	a_freeze_hold: assert property (frozen_out && $past(frozen_out) |-> $stable(analog_out))
		else $error("analog out moved while frozen");
	a_live_follow: assert property (!frozen_out [*3] |-> analog_out == $past(analog_in))
		else $error("analog out not following input");
	a_heat_frozen: assert property (heater_full_out |-> frozen_out)
		else $error("heater on without freeze");
	a_overheat_on: assert property (continuous_overheat_out == DUAL_HEAT)
		else $error("overheat output wrong");
	a_btn_start: assert property ($rose(board_pushbutton_in) && !frozen_out |-> ##[1:3] heater_full_out)
		else $error("button did not start heating");
	a_ext_start: assert property ($rose(ext_trigger_in) && !frozen_out |-> ##[1:3] heater_full_out)
		else $error("trigger did not start heating");
	a_cycle_heat: assert property ($rose(frozen_out) |-> heater_full_out)
		else $error("cycle began without heating");
	a_cool_held: assert property ($fell(heater_full_out) && !$past(sys_rst_in) |-> frozen_out)
		else $error("no cool-down after heating");
	a_reset_quiet: assert property ($fell(sys_rst_in) |-> !heater_full_out && !frozen_out)
		else $error("outputs active after reset");
	a_no_retrig: assert property (frozen_out && !heater_full_out && $rose(board_pushbutton_in) ##1 frozen_out [*2]
		|-> !heater_full_out)
		else $error("start taken during cool-down");
	c_heat: cover property (heater_full_out [*8]);
	c_cool: cover property ($fell(heater_full_out));
	c_retrig: cover property (frozen_out && $rose(board_pushbutton_in));
endmodule

//--- tb/testbench.sv
// self-checking bench of the heater sequencer
`timescale 1ns/10ps
`include "shms_params.svh"
module testbench;
	import shms_pkg::*;
	localparam int TD = 2;
	logic         clk_sys_in = 0, sys_rst_in = 1, psel = 0, penable = 0, pwrite = 0, btn = 0, ext = 0;
	logic [11:0]  paddr = '0;
	logic [31:0]  pwdata = '0, prdata;
	logic         pready, pslverr, heater, frz, ovh;
	shms_analog_s a_out, held;
	int           mv = 0;
	logic [9:0]   rh_t = 10'h1F4, rh;
	shms_analog_s a_in;
	logic [32:0]  q[$];
	int           failures = 0, cmp_count = 0, cyc = 0, h, f, w;
	always #5 clk_sys_in = ~clk_sys_in;
	shms_env_model env (.clk_sys_in(clk_sys_in), .rh_target_in(rh_t), .humidity_out(rh), .analog_out(a_in));
	shms_sequencer #(.TICK_DIV(TD), .DUAL_HEAT(1'b0)) dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .humidity_in(rh), .board_pushbutton_in(btn),
		.ext_trigger_in(ext), .analog_in(a_in), .heater_full_out(heater), .continuous_overheat_out(ovh),
		.analog_out(a_out), .frozen_out(frz));
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rng(input int v, input int n);
		chk(33'(v >= (n - 2) * TD && v <= (n + 2) * TD + 2), 33'h1);
	endtask
	task automatic apb(input logic [11:0] a, input logic wr, input logic [31:0] d, input logic [32:0] e);
		@(posedge clk_sys_in);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_in);
		penable <= 1'b1;
		if (!wr) q.push_back(e);
		do @(posedge clk_sys_in); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic run_cycle();
		w = 0;
		h = 0;
		f = 0;
		mv = 0;
		@(negedge clk_sys_in);
		while (!heater) begin
			@(negedge clk_sys_in);
			w++;
		end
		held = a_out;
		while (frz) begin
			if (heater) h++;
			if (a_out !== held) mv++;
			f++;
			@(negedge clk_sys_in);
		end
		chk(33'(mv), 33'h0);
	endtask
	task automatic press(input logic b);
		@(posedge clk_sys_in);
		if (b) btn <= 1'b1; else ext <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		if (b) btn <= 1'b0; else ext <= 1'b0;
	endtask
	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys_in) begin
		cyc++;
		if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, q.pop_front());
		if (cyc == 20000) begin
			failures++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(32'h6d83));
		repeat (3) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		apb(`SHMS_OFS_CTRL, 1'b0, 32'h0, 33'h0);
		apb(`SHMS_OFS_SETPOINT, 1'b0, 32'h0, 33'h3DE);
		apb(12'h018, 1'b0, 32'h0, 33'h100000000);
		apb(`SHMS_OFS_BAKE_HEAT, 1'b1, 32'h3, 33'h0);
		apb(`SHMS_OFS_BAKE_COOL, 1'b1, 32'h4, 33'h0);
		apb(`SHMS_OFS_BAKE_HEAT, 1'b0, 32'h0, 33'h3);
		$display("done: registers");
		fork run_cycle(); press(1'b1); join
		rng(h, 3);
		rng(f, 7);
		fork
			run_cycle();
			press(1'b0);
			repeat (2) begin
				repeat (4) @(posedge clk_sys_in);
				press(1'b1);
			end
		join
		rng(h, 3);
		rng(f, 7);
		fork run_cycle(); apb(`SHMS_OFS_CTRL, 1'b1, 32'h4, 33'h0); join
		rng(h, 3);
		apb(`SHMS_OFS_BAKE_PERIOD, 1'b1, 32'h6, 33'h0);
		fork run_cycle(); apb(`SHMS_OFS_CTRL, 1'b1, 32'h2, 33'h0); join
		chk(33'(w <= 8 * TD), 33'h1);
		apb(`SHMS_OFS_CTRL, 1'b1, 32'h0, 33'h0);
		repeat (20) @(negedge clk_sys_in);
		while (frz) @(negedge clk_sys_in);
		$display("done: bake");
		rh_t <= 10'h3DE + 10'($urandom % 34);
		apb(`SHMS_OFS_CTRL, 1'b1, 32'h1, 33'h0);
		run_cycle();
		rng(h, 10);
		rng(f, 190);
		run_cycle();
		rng(w, 1620);
		rng(h, 10);
		apb(`SHMS_OFS_CTRL, 1'b1, 32'h0, 33'h0);
		chk(33'(ovh), 33'h0);
		$display("done: purge");
		finish_test();
	end
endmodule
bind shms_sequencer shms_seq_monitor #(.DUAL_HEAT(DUAL_HEAT)) mon (.*);
